// *** pxb_pkg.sv ***
// constants shared by the priority pin crossbar
package pxb_pkg;

  // pin counts: three byte ports plus a five bit port
  localparam int unsigned NUM_PINS  = 29;
  localparam int unsigned XBAR_PINS = 20;
  localparam int unsigned NUM_SIG   = 17;
  localparam int unsigned OWN_W     = 5;

  // pin owner codes: 0 is general purpose, 1..17 is signal index plus one
  localparam logic [4:0] OWN_NONE = 5'h00;
  localparam logic [4:0] OWN_TX   = 5'h12;
  localparam logic [4:0] OWN_RX   = 5'h13;

  // fixed serial port pins
  localparam int unsigned UART_TX_PIN = 4;
  localparam int unsigned UART_RX_PIN = 5;

  // route_select_low field positions
  localparam int unsigned LOW_UART   = 0;
  localparam int unsigned LOW_SPI    = 1;
  localparam int unsigned LOW_SMB    = 2;
  localparam int unsigned LOW_SYSCLK = 3;
  localparam int unsigned LOW_CP0    = 4;
  localparam int unsigned LOW_CP0A   = 5;
  localparam int unsigned LOW_CP1    = 6;
  localparam int unsigned LOW_CP1A   = 7;

  // route_select_high field positions
  localparam int unsigned HIGH_CMP_LSB = 0;
  localparam int unsigned HIGH_EXT_CNT = 3;
  localparam int unsigned HIGH_T0      = 4;
  localparam int unsigned HIGH_T1      = 5;
  localparam int unsigned HIGH_ON      = 6;
  localparam int unsigned HIGH_PUD     = 7;

  // ext_irq_pin_config field positions
  localparam int unsigned IRQ_A_SEL_LSB = 0;
  localparam int unsigned IRQ_A_POL     = 3;
  localparam int unsigned IRQ_B_SEL_LSB = 4;
  localparam int unsigned IRQ_B_POL     = 7;

  // peripheral signals in crossbar priority order
  localparam int unsigned SIG_SCK       = 0;
  localparam int unsigned SIG_MISO      = 1;
  localparam int unsigned SIG_MOSI      = 2;
  localparam int unsigned SIG_SLAVE_SEL = 3;
  localparam int unsigned SIG_SDA       = 4;
  localparam int unsigned SIG_SCL       = 5;
  localparam int unsigned SIG_CP0       = 6;
  localparam int unsigned SIG_CP0A      = 7;
  localparam int unsigned SIG_CP1       = 8;
  localparam int unsigned SIG_CP1A      = 9;
  localparam int unsigned SIG_SYSCLK    = 10;
  localparam int unsigned SIG_CMP_OUT0  = 11;
  localparam int unsigned SIG_EXT_CNT   = 14;
  localparam int unsigned SIG_T0        = 15;
  localparam int unsigned SIG_T1        = 16;

  // values held during reset: digital inputs, weak pullups on, no drive
  localparam logic [28:0] RST_PAD_OE  = 29'h00000000;
  localparam logic [28:0] RST_PAD_OUT = 29'h1FFFFFFF;
  localparam logic [28:0] RST_PULLUP  = 29'h1FFFFFFF;
  localparam logic [28:0] RST_RX_EN   = 29'h1FFFFFFF;
  localparam logic [28:0] RST_READ    = 29'h00000000;
  localparam logic [16:0] RST_PIN_IN  = 17'h00000;

endpackage : pxb_pkg

// *** pxb_crossbar.sv ***
// priority pin crossbar: pin allocation, pad control and pin read-back
module pxb_crossbar (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  // configuration
  input  wire logic [pxb_pkg::NUM_PINS-1:0] pin_skip_mask_i,
  input  wire logic [pxb_pkg::NUM_PINS-1:0] pin_input_mode_i,
  input  wire logic [pxb_pkg::NUM_PINS-1:0] pin_output_mode_i,
  input  wire logic [7:0]                   route_select_low_i,
  input  wire logic [7:0]                   route_select_high_i,
  input  wire logic [1:0]                   slave_select_mode_i,
  input  wire logic [7:0]                   ext_irq_pin_config_i,
  input  wire logic [pxb_pkg::NUM_PINS-1:0] port_latch_i,
  // peripheral side
  input  wire logic [pxb_pkg::NUM_SIG-1:0]  periph_out_i,
  input  wire logic [pxb_pkg::NUM_SIG-1:0]  periph_oe_i,
  output logic      [pxb_pkg::NUM_SIG-1:0]  periph_in_o,
  input  wire logic                         serial_tx_line_i,
  output logic                              serial_rx_line_o,
  output logic                              ext_irq_a_o,
  output logic                              ext_irq_b_o,
  // pad side
  input  wire logic [pxb_pkg::NUM_PINS-1:0] pad_in_i,
  output logic      [pxb_pkg::NUM_PINS-1:0] pad_out_o,
  output logic      [pxb_pkg::NUM_PINS-1:0] pad_oe_o,
  output logic      [pxb_pkg::NUM_PINS-1:0] pad_pullup_o,
  output logic      [pxb_pkg::NUM_PINS-1:0] pad_rx_en_o,
  // status
  output logic      [pxb_pkg::NUM_PINS-1:0] port_read_o,
  output logic [pxb_pkg::XBAR_PINS-1:0][pxb_pkg::OWN_W-1:0] pin_owner_o
);

  logic                        xbar_on;
  logic                        pud;
  logic                        uart_en;
  logic [pxb_pkg::NUM_SIG-1:0] sig_en;
  logic [1:0]                  cmp_cnt;

  logic [pxb_pkg::XBAR_PINS-1:0][pxb_pkg::OWN_W-1:0] nxt_owner;
  logic [pxb_pkg::XBAR_PINS-1:0][pxb_pkg::OWN_W-1:0] owner_ff;
  logic [pxb_pkg::XBAR_PINS-1:0]                     occ;
  logic                                              found;

  logic [pxb_pkg::NUM_PINS-1:0] nxt_pad_out;
  logic [pxb_pkg::NUM_PINS-1:0] nxt_pad_oe;
  logic [pxb_pkg::NUM_PINS-1:0] nxt_pullup;
  logic [pxb_pkg::NUM_PINS-1:0] nxt_rx_en;
  logic [pxb_pkg::NUM_PINS-1:0] nxt_read;
  logic [pxb_pkg::NUM_SIG-1:0]  nxt_periph_in;
  logic                         nxt_rx_line;
  logic                         nxt_irq_a;
  logic                         nxt_irq_b;
  logic [pxb_pkg::NUM_PINS-1:0] pad_out_ff;
  logic [pxb_pkg::NUM_PINS-1:0] pad_oe_ff;
  logic [pxb_pkg::NUM_PINS-1:0] pullup_ff;
  logic [pxb_pkg::NUM_PINS-1:0] rx_en_ff;
  logic [pxb_pkg::NUM_PINS-1:0] read_ff;
  logic [pxb_pkg::NUM_SIG-1:0]  periph_in_ff;
  logic                         rx_line_ff;
  logic                         irq_a_ff;
  logic                         irq_b_ff;

  // interrupt pin pick: digital pins only, level compared to polarity
  function automatic logic irq_hit(input logic [2:0] sel, input logic pol,
                                   input logic [7:0] lvl, input logic [7:0] dig);
    irq_hit = dig[sel] && (lvl[sel] == pol);
  endfunction

  assign xbar_on = route_select_high_i[pxb_pkg::HIGH_ON];
  assign pud     = route_select_high_i[pxb_pkg::HIGH_PUD];
  assign uart_en = route_select_low_i[pxb_pkg::LOW_UART];
  assign cmp_cnt = route_select_high_i[pxb_pkg::HIGH_CMP_LSB +: 2];

  // per-signal requests; whole peripherals except SPI slave select (not in 3-wire mode) and comparator outputs (by count)
  always_comb begin
    sig_en                       = '0;
    sig_en[pxb_pkg::SIG_SCK]     = route_select_low_i[pxb_pkg::LOW_SPI];
    sig_en[pxb_pkg::SIG_MISO]    = route_select_low_i[pxb_pkg::LOW_SPI];
    sig_en[pxb_pkg::SIG_MOSI]    = route_select_low_i[pxb_pkg::LOW_SPI];
    sig_en[pxb_pkg::SIG_SLAVE_SEL] = route_select_low_i[pxb_pkg::LOW_SPI]
                                     && (slave_select_mode_i != 2'h0);
    sig_en[pxb_pkg::SIG_SDA]     = route_select_low_i[pxb_pkg::LOW_SMB];
    sig_en[pxb_pkg::SIG_SCL]     = route_select_low_i[pxb_pkg::LOW_SMB];
    sig_en[pxb_pkg::SIG_CP0]     = route_select_low_i[pxb_pkg::LOW_CP0];
    sig_en[pxb_pkg::SIG_CP0A]    = route_select_low_i[pxb_pkg::LOW_CP0A];
    sig_en[pxb_pkg::SIG_CP1]     = route_select_low_i[pxb_pkg::LOW_CP1];
    sig_en[pxb_pkg::SIG_CP1A]    = route_select_low_i[pxb_pkg::LOW_CP1A];
    sig_en[pxb_pkg::SIG_SYSCLK]  = route_select_low_i[pxb_pkg::LOW_SYSCLK];
    sig_en[pxb_pkg::SIG_CMP_OUT0]   = (cmp_cnt != 2'h0);
    sig_en[pxb_pkg::SIG_CMP_OUT0+1] = (cmp_cnt[1] == 1'b1);
    sig_en[pxb_pkg::SIG_CMP_OUT0+2] = (cmp_cnt == 2'h3);
    sig_en[pxb_pkg::SIG_EXT_CNT]    = route_select_high_i[pxb_pkg::HIGH_EXT_CNT];
    sig_en[pxb_pkg::SIG_T0]      = route_select_high_i[pxb_pkg::HIGH_T0];
    sig_en[pxb_pkg::SIG_T1]      = route_select_high_i[pxb_pkg::HIGH_T1];
  end

  // priority allocation over the crossbar pins
  always_comb begin
    found     = 1'b0;
    occ       = pin_skip_mask_i[pxb_pkg::XBAR_PINS-1:0];
    nxt_owner = '0;
    if (uart_en) begin
      occ[pxb_pkg::UART_TX_PIN]       = 1'b1;
      occ[pxb_pkg::UART_RX_PIN]       = 1'b1;
      nxt_owner[pxb_pkg::UART_TX_PIN] = pxb_pkg::OWN_TX;
      nxt_owner[pxb_pkg::UART_RX_PIN] = pxb_pkg::OWN_RX;
    end
    for (int s = 0; s < pxb_pkg::NUM_SIG; s++) begin
      found = 1'b0;
      if (sig_en[s]) begin
        for (int p = 0; p < pxb_pkg::XBAR_PINS; p++) begin
          if (!found && !occ[p]) begin
            nxt_owner[p] = 5'(s + 1);
            occ[p]       = 1'b1;
            found        = 1'b1;
          end
        end
      end
    end
    if (!xbar_on) begin
      nxt_owner = '0;
    end
  end

  // pad control for every pin
  always_comb begin
    logic [pxb_pkg::OWN_W-1:0] own;
    logic                      val;
    logic                      req;
    logic                      smb;
    logic                      od;
    logic                      drv;
    own           = pxb_pkg::OWN_NONE;
    val           = 1'b0;
    req           = 1'b0;
    smb           = 1'b0;
    od            = 1'b0;
    drv           = 1'b0;
    nxt_pad_out   = '0;
    nxt_pad_oe    = '0;
    nxt_pullup    = '0;
    nxt_rx_en     = '0;
    nxt_periph_in = '0;
    for (int p = 0; p < pxb_pkg::NUM_PINS; p++) begin
      own = pxb_pkg::OWN_NONE;
      if (p < pxb_pkg::XBAR_PINS) begin
        own = nxt_owner[p[4:0]];
      end
      val = port_latch_i[p];
      req = 1'b1;
      smb = 1'b0;
      if (own == pxb_pkg::OWN_TX) begin
        val = serial_tx_line_i;
      end else if (own == pxb_pkg::OWN_RX) begin
        req = 1'b0;
      end else if (own != pxb_pkg::OWN_NONE) begin
        val = periph_out_i[own - 5'h01];
        req = periph_oe_i[own - 5'h01];
        smb = (own == 5'(pxb_pkg::SIG_SDA + 1)) || (own == 5'(pxb_pkg::SIG_SCL + 1));
        nxt_periph_in[own - 5'h01] = pad_in_i[p] & pin_input_mode_i[p];
      end
      od  = !pin_output_mode_i[p] || smb;
      drv = xbar_on && pin_input_mode_i[p] && req && (!od || !val);
      nxt_pad_out[p] = val;
      nxt_pad_oe[p]  = drv;
      nxt_pullup[p]  = pin_input_mode_i[p] && !pud && (!xbar_on || od) && !drv;
      nxt_rx_en[p]   = pin_input_mode_i[p];
    end
  end

  always_comb begin
    nxt_read    = pad_in_i & pin_input_mode_i;
    nxt_rx_line = 1'b1;
    if (uart_en && xbar_on) begin
      nxt_rx_line = pad_in_i[pxb_pkg::UART_RX_PIN] & pin_input_mode_i[pxb_pkg::UART_RX_PIN];
    end
    nxt_irq_a = irq_hit(ext_irq_pin_config_i[pxb_pkg::IRQ_A_SEL_LSB +: 3],
                        ext_irq_pin_config_i[pxb_pkg::IRQ_A_POL],
                        pad_in_i[7:0], pin_input_mode_i[7:0]);
    nxt_irq_b = irq_hit(ext_irq_pin_config_i[pxb_pkg::IRQ_B_SEL_LSB +: 3],
                        ext_irq_pin_config_i[pxb_pkg::IRQ_B_POL],
                        pad_in_i[7:0], pin_input_mode_i[7:0]);
  end

  // every output registered; settings take hold at the next edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      owner_ff     <= '0;
      pad_out_ff   <= pxb_pkg::RST_PAD_OUT;
      pad_oe_ff    <= pxb_pkg::RST_PAD_OE;
      pullup_ff    <= pxb_pkg::RST_PULLUP;
      rx_en_ff     <= pxb_pkg::RST_RX_EN;
      read_ff      <= pxb_pkg::RST_READ;
      periph_in_ff <= pxb_pkg::RST_PIN_IN;
      rx_line_ff   <= 1'b1;
      irq_a_ff     <= 1'b0;
      irq_b_ff     <= 1'b0;
    end else begin
      owner_ff     <= nxt_owner;
      pad_out_ff   <= nxt_pad_out;
      pad_oe_ff    <= nxt_pad_oe;
      pullup_ff    <= nxt_pullup;
      rx_en_ff     <= nxt_rx_en;
      read_ff      <= nxt_read;
      periph_in_ff <= nxt_periph_in;
      rx_line_ff   <= nxt_rx_line;
      irq_a_ff     <= nxt_irq_a;
      irq_b_ff     <= nxt_irq_b;
    end
  end

  assign pin_owner_o      = owner_ff;
  assign pad_out_o        = pad_out_ff;
  assign pad_oe_o         = pad_oe_ff;
  assign pad_pullup_o     = pullup_ff;
  assign pad_rx_en_o      = rx_en_ff;
  assign port_read_o      = read_ff;
  assign periph_in_o      = periph_in_ff;
  assign serial_rx_line_o = rx_line_ff;
  assign ext_irq_a_o      = irq_a_ff;
  assign ext_irq_b_o      = irq_b_ff;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_smb_only;
    route_select_low_i == 8'h04 && route_select_high_i == 8'h40 && pin_skip_mask_i == '0;
  endsequence
  sequence s_smb_low_pins;
    owner_ff[0] == 5'h05 && owner_ff[1] == 5'h06 && owner_ff[2] == pxb_pkg::OWN_NONE;
  endsequence

  property p_lowest_pair;
    s_smb_only |=> s_smb_low_pins;
  endproperty
  a_lowest_pair: assert property (p_lowest_pair) else $error("bus pair not on lowest pins");

  // pins carrying a routed signal other than the fixed serial pair
  logic [pxb_pkg::XBAR_PINS-1:0] routed;
  for (genvar g = 0; g < pxb_pkg::XBAR_PINS; g++) begin : g_routed
    assign routed[g] = (owner_ff[g] != pxb_pkg::OWN_NONE) && (owner_ff[g] < pxb_pkg::OWN_TX);
  end

  property p_skip_honoured;
    xbar_on |=> (routed & $past(pin_skip_mask_i[pxb_pkg::XBAR_PINS-1:0])) == '0;
  endproperty
  a_skip_honoured: assert property (p_skip_honoured) else $error("skipped pin routed");

  property p_uart_fixed;
    uart_en && xbar_on |=> owner_ff[4] == pxb_pkg::OWN_TX && owner_ff[5] == pxb_pkg::OWN_RX;
  endproperty
  a_uart_fixed: assert property (p_uart_fixed) else $error("serial lines not on fixed pins");

  property p_spi_three;
    route_select_low_i == 8'h02 && route_select_high_i == 8'h40 && slave_select_mode_i == 2'h0
      && pin_skip_mask_i == '0 |=> owner_ff[2] == 5'h03 && owner_ff[3] == pxb_pkg::OWN_NONE;
  endproperty
  a_spi_three: assert property (p_spi_three) else $error("slave select routed in 3-wire");

  property p_off_no_drive;
    !xbar_on |=> pad_oe_o == '0 && owner_ff == '0;
  endproperty
  a_off_no_drive: assert property (p_off_no_drive) else $error("driver on with crossbar off");

  property p_analog_quiet;
    1'b1 |=> ((pad_oe_o | pad_pullup_o | pad_rx_en_o | port_read_o)
              & ~$past(pin_input_mode_i)) == '0;
  endproperty
  a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin not isolated");

  property p_pud_off;
    pud |=> pad_pullup_o == '0;
  endproperty
  a_pud_off: assert property (p_pud_off) else $error("pullup on while disabled");

  property p_smb_open_drain;
    xbar_on && route_select_low_i[pxb_pkg::LOW_SMB] && periph_out_i[pxb_pkg::SIG_SDA]
      && pin_skip_mask_i == '0 && !uart_en && !route_select_low_i[pxb_pkg::LOW_SPI]
      |=> !pad_oe_o[0];
  endproperty
  a_smb_open_drain: assert property (p_smb_open_drain) else $error("bus data driven high");

  property p_irq_analog;
    !pin_input_mode_i[ext_irq_pin_config_i[2:0]] |=> !ext_irq_a_o;
  endproperty
  a_irq_analog: assert property (p_irq_analog) else $error("interrupt from analog pin");

  property p_gpio_follow;
    xbar_on && !uart_en && sig_en == '0 && pin_input_mode_i[24] && pin_output_mode_i[24]
      |=> pad_oe_o[24] && pad_out_o[24] == $past(port_latch_i[24]);
  endproperty
  a_gpio_follow: assert property (p_gpio_follow) else $error("free pin not general purpose");

endmodule : pxb_crossbar

// *** pxb_far_model.sv ***
// far-side model: pad wiring, board drive and on-chip peripheral requests
module pxb_far_model (
  // clock
  input  wire logic        clk_i,
  // pad control from the crossbar
  input  wire logic [28:0] pad_out_i,
  input  wire logic [28:0] pad_oe_i,
  input  wire logic [28:0] pad_pullup_i,
  // board drive and resolved pad level
  input  wire logic [28:0] ext_en_i,
  input  wire logic [28:0] ext_val_i,
  output logic      [28:0] pad_in_o,
  // peripheral requests
  input  wire logic [16:0] per_val_i,
  input  wire logic [16:0] per_drv_i,
  output logic      [16:0] periph_out_o,
  output logic      [16:0] periph_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [28:0] last_ff = 29'h00000000;

  // undriven and unpulled pads wander instead of holding
  always_comb begin
    for (int i = 0; i < 29; i++) begin
      if (pad_oe_i[i]) pad_in_o[i] = pad_out_i[i];
      else if (ext_en_i[i]) pad_in_o[i] = ext_val_i[i];
      else if (pad_pullup_i[i]) pad_in_o[i] = 1'h1;
      else pad_in_o[i] = ~last_ff[i];
    end
  end

  always_ff @(posedge clk_i) last_ff <= pad_in_o;

  assign periph_out_o = per_val_i;
  assign periph_oe_o  = per_drv_i;
endmodule // pxb_far_model

// *** tb.sv ***
// self-checking bench for the priority pin crossbar
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk_i;
  logic             rst_n_i;
  logic [28:0]      skip, imode, omode, latch, ext_en, ext_val;
  logic [7:0]       lo, hi, irqc;
  logic [1:0]       ssm;
  logic [16:0]      pval, pdrv, per_out, per_oe, per_in;
  logic             tx, rx, ia, ib;
  logic [28:0]      pin, pout, poe, ppu, prx, prd;
  logic [19:0][4:0] own;
  int               err_count, n_compared;

  pxb_crossbar pxb_crossbar_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pin_skip_mask_i(skip), .pin_input_mode_i(imode),
    .pin_output_mode_i(omode), .route_select_low_i(lo), .route_select_high_i(hi),
    .slave_select_mode_i(ssm), .ext_irq_pin_config_i(irqc), .port_latch_i(latch),
    .periph_out_i(per_out), .periph_oe_i(per_oe), .periph_in_o(per_in), .serial_tx_line_i(tx),
    .serial_rx_line_o(rx), .ext_irq_a_o(ia), .ext_irq_b_o(ib), .pad_in_i(pin), .pad_out_o(pout),
    .pad_oe_o(poe), .pad_pullup_o(ppu), .pad_rx_en_o(prx), .port_read_o(prd), .pin_owner_o(own));

  pxb_far_model pxb_far_model_inst (
    .clk_i(clk_i), .pad_out_i(pout), .pad_oe_i(poe), .pad_pullup_i(ppu), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pad_in_o(pin), .per_val_i(pval), .per_drv_i(pdrv),
    .periph_out_o(per_out), .periph_oe_o(per_oe));

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [28:0] got, input logic [28:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // software order: input mode, output mode, skip, selections, enable last
  task automatic cfg(input logic [28:0] sk, input logic [7:0] l, input logic [7:0] h);
    @(negedge clk_i);
    skip = sk;
    lo = l;
    hi = h;
  endtask

  task automatic t_reset;
    chk(poe, 29'h0);
    chk(ppu, 29'h1FFFFFFF);
    chk(prx, 29'h1FFFFFFF);
    chk(rx, 1'h1);
  endtask

  task automatic t_off;
    @(negedge clk_i);
    omode = '1;
    latch = '0;
    cfg(29'h0, 8'h07, 8'h00);
    cyc(1);
    chk(poe, 29'h0);
    chk(own[0], 5'h00);
  endtask

  task automatic t_ex1;
    @(negedge clk_i);
    omode = '0;
    latch = '1;
    cfg(29'h0, 8'h0D, 8'h40);
    tx = 1'h0;
    ext_en = 29'h20;
    ext_val = 29'h0;
    cyc(1);
    chk(own[3:0], {5'h00, 5'h0B, 5'h06, 5'h05});
    chk(own[5:4], {5'h13, 5'h12});
    chk(pout[4], 1'h0);
    chk(rx, 1'h0);
  endtask

  task automatic t_ex2;
    cfg(29'h3, 8'h0D, 8'h40);
    ext_en = 29'h0;
    cyc(1);
    chk(own[3:0], {5'h06, 5'h05, 5'h00, 5'h00});
    chk(own[6], 5'h0B);
  endtask

  task automatic t_spi;
    cfg(29'h0, 8'h06, 8'h40);
    ssm = 2'h0;
    cyc(1);
    chk(own[4:0], {5'h06, 5'h05, 5'h03, 5'h02, 5'h01});
    @(negedge clk_i);
    ssm = 2'h1;
    cyc(1);
    chk(own[3:0], {5'h04, 5'h03, 5'h02, 5'h01});
    chk(own[5:4], {5'h06, 5'h05});
    @(negedge clk_i);
    lo = 8'h02;
    ssm = 2'h0;
    cyc(1);
    chk(own[3:0], {5'h00, 5'h03, 5'h02, 5'h01});
  endtask

  task automatic t_edge;
    cfg(29'h007FFFF, 8'h04, 8'h40);
    cyc(2);
    chk(own[19], 5'h05);
    chk(per_in[5], 1'h0);
    @(negedge clk_i);
    skip = '0;
    cyc(1);
    chk(own[1:0], {5'h06, 5'h05});
  endtask

  task automatic t_drive;
    @(negedge clk_i);
    omode = '1;
    latch = 29'h1FFFFFF7;
    cfg(29'h0, 8'h0C, 8'h40);
    pval = 17'h00410;
    pdrv = 17'h00430;
    cyc(2);
    chk(poe[3:0], 4'hE);
    chk(pout[3:2], 2'h1);
    chk(ppu[3:0], 4'h1);
    chk(per_in[4], 1'h1);
    @(negedge clk_i);
    hi = 8'hC0;
    cyc(1);
    chk(ppu[3:0], 4'h0);
  endtask

  task automatic t_analog;
    @(negedge clk_i);
    imode = 29'h1FFFFF7F;
    omode = 29'h01000080;
    latch = 29'h1FFFFF7F;
    cfg(29'h80, 8'h00, 8'h40);
    ext_en = 29'hC0;
    ext_val = 29'hC0;
    irqc = 8'hEF;
    cyc(2);
    chk({prx[7], ppu[7], poe[7]}, 3'h0);
    chk(prd[7:6], 2'h1);
    chk(ia, 1'h0);
    chk(ib, 1'h1);
    @(negedge clk_i);
    imode = '1;
    omode = '0;
    latch = '1;
    cyc(2);
    chk(ia, 1'h1);
    chk(prd[7], 1'h1);
  endtask

  initial begin
    err_count = 0;
    n_compared = 0;
    rst_n_i = 1'h0;
    skip = '0;
    imode = '1;
    omode = '0;
    latch = '1;
    ext_en = '0;
    ext_val = '0;
    lo = 8'h00;
    hi = 8'h00;
    irqc = 8'h00;
    ssm = 2'h0;
    pval = '0;
    pdrv = '0;
    tx = 1'h1;
    repeat (4) @(negedge clk_i);
    t_reset;
    @(negedge clk_i);
    rst_n_i = 1'h1;
    t_off;
    t_ex1;
    t_ex2;
    t_spi;
    t_edge;
    t_drive;
    t_analog;
    print_verdict;
  end

  // the run needs well under 100 cycles
  initial begin
    #20000;
    err_count++;
    print_verdict;
  end
endmodule // tb
